// ===== inc/serial_link_pkg.sv
/*
  Shared constants and types for the fast serial flash link device end.
  Assumes a 100 MHz core clock that oversamples the host's serial clock.
*/
`default_nettype none
package serial_link_pkg;
  // ==========================================================
  // Word and synchroniser sizes
  localparam int BYTE_BITS = 8;
  localparam int SYNC_STAGES = 2;
  localparam int LINK_PINS = 3;

  // ==========================================================
  // Timing
  localparam int CORE_CLK_PERIOD_NS = 10;
  localparam int CLOCK_LOW_PHASE_TIME_NS = 4;
  localparam int MAX_LINK_FREQ_MHZ = 85;
  localparam int BENCH_LINK_PERIOD_NS = 80;
  // Pin to output: two sync stages and the output stage; the edge compare adds none
  localparam int LINK_OUT_LATENCY_CYC = SYNC_STAGES + 1;
  localparam int LINK_OUT_LATENCY_NS = LINK_OUT_LATENCY_CYC * CORE_CLK_PERIOD_NS;
  // Low phase of the slowest supported bench clock, in core cycles, rounded down
  localparam int BENCH_LOW_PHASE_CYC = (BENCH_LINK_PERIOD_NS / 2) / CORE_CLK_PERIOD_NS;

  // ==========================================================
  // Reset values
  localparam logic RESET_SO = 1'b1;
  localparam logic [7:0] RESET_BYTE = 8'h00;

  // ==========================================================
  // Types
  typedef struct packed {
    logic cs_b;
    logic sclk;
    logic si;
  } link_pins_t;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rx_byte_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_SELECTED = 1'b1
  } link_state_t;
endpackage
`default_nettype wire

// ===== design/link_pin_sync.sv
/*
  Two-flop synchroniser for a group of pins from outside the core clock domain.
  Assumes an active-low reset already synchronised to the core clock.
*/
`timescale 1ns/1ns
`default_nettype none
module link_pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic [WIDTH-1:0] pins_i,
  output logic [WIDTH-1:0] pins_o
);
  // ==========================================================
  // Elaboration check
  if (WIDTH < 1)
  begin : g_bad_width
    $error("synchroniser needs at least one pin");
  end

  // ==========================================================
  // One independent pair per pin; first stage feeds only the second
  for (genvar g = 0; g < WIDTH; g++)
  begin : g_bit
    logic meta;
    always_ff @(posedge core_clk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        meta <= RESET_VALUE[g];
        pins_o[g] <= RESET_VALUE[g];
      end
      else
      begin
        meta <= pins_i[g];
        pins_o[g] <= meta;
      end
    end
  end
endmodule
`default_nettype wire

// ===== design/fast_serial_flash_link.sv
/*
  Device end of the fast full-cycle serial flash link: byte receive and
  response transmit, with mode 0 / mode 3 detection at chip select.
  Assumes the host makes the serial clock and keeps its own edge discipline;
  the user side supplies each response byte before the command byte ends.
*/
`timescale 1ns/1ns
`default_nettype none
module fast_serial_flash_link
(
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic cs_b_i,
  input wire logic sclk_i,
  input wire logic si_i,
  output logic so_o,
  output logic so_oe_o,
  input wire logic [7:0] tx_data_i,
  output serial_link_pkg::rx_byte_t rx_o,
  output logic mode3_o
);
  import serial_link_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (LINK_OUT_LATENCY_NS >= BENCH_LINK_PERIOD_NS / 2)
  begin : g_bad_latency
    $error("output latency does not fit the serial clock low phase");
  end
  if (BYTE_BITS != 8)
  begin : g_bad_byte
    $error("byte width must be eight");
  end

  // ==========================================================
  // Reset release
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ==========================================================
  // Pin synchronisers and edge detection
  link_pins_t pins_raw;
  link_pins_t pins;
  logic sclk_q;
  logic cs_b_q;
  logic si_q;
  assign pins_raw = '{cs_b: cs_b_i, sclk: sclk_i, si: si_i};

  link_pin_sync #(
    .WIDTH(LINK_PINS),
    .RESET_VALUE(3'h4)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n),
    .pins_i(pins_raw),
    .pins_o(pins)
  );

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_q <= 1'b0;
      cs_b_q <= 1'b1;
      si_q <= 1'b0;
    end
    else
    begin
      sclk_q <= pins.sclk;
      cs_b_q <= pins.cs_b;
      si_q <= pins.si;
    end
  end

  wire sclk_rise = pins.sclk & ~sclk_q;
  wire sclk_fall = ~pins.sclk & sclk_q;
  wire cs_fall = ~pins.cs_b & cs_b_q;
  wire deselect = pins.cs_b;

  // ==========================================================
  // Link state
  link_state_t state;
  link_state_t next_state;
  always_comb
  begin
    next_state = state;
    unique case (state)
      ST_IDLE:
        if (cs_fall)
          next_state = ST_SELECTED;
      ST_SELECTED:
        if (deselect)
          next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_IDLE;
    else
      state <= next_state;
  end

  wire selected = (state == ST_SELECTED) && !deselect;

  // ==========================================================
  // Receive path: clock ignored unless selected
  logic [2:0] bit_cnt;
  logic [7:0] rx_shift;
  wire rx_take = selected && sclk_rise;
  wire byte_done = rx_take && (bit_cnt == 3'h7);
  // Data from the cycle before the detected rise: the host moves its bit on
  // that same rise, and both cross the synchroniser together
  wire [7:0] rx_next = {rx_shift[6:0], si_q};

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt <= 3'h0;
      rx_shift <= RESET_BYTE;
      rx_o <= '0;
      mode3_o <= 1'b0;
    end
    else
    begin
      rx_o.valid <= byte_done;
      if (cs_fall)
      begin
        bit_cnt <= 3'h0;
        mode3_o <= pins.sclk;
      end
      else if (rx_take)
      begin
        rx_shift <= rx_next;
        bit_cnt <= bit_cnt + 3'h1;
      end
      if (byte_done)
        rx_o.data <= rx_next;
    end
  end

  // ==========================================================
  // Transmit path: loaded at byte end, shifted on falling edges.
  // Output changes a fixed few core cycles after the pin edge, which keeps
  // it inside the low phase for the slower bench clock; a faster clock
  // trades that for full-cycle capture by the host.
  logic [7:0] tx_shift;
  logic tx_live;
  wire tx_step = selected && sclk_fall && tx_live;

  always_ff @(posedge core_clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_shift <= RESET_BYTE;
      tx_live <= 1'b0;
      so_o <= RESET_SO;
      so_oe_o <= 1'b0;
    end
    else
    begin
      if (!selected)
      begin
        tx_live <= 1'b0;
        so_oe_o <= 1'b0;
      end
      else if (byte_done)
      begin
        tx_shift <= tx_data_i;
        tx_live <= 1'b1;
      end
      else if (tx_step)
      begin
        so_o <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
        so_oe_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n);

  a_so_on_fall: assert property ($changed(so_o) |-> $past(sclk_fall))
    else $error("serial output changed without a falling clock edge");
  a_byte_on_rise: assert property (rx_o.valid |-> $past(sclk_rise))
    else $error("byte completed without a rising clock edge");
  a_eighth_rise: assert property (rx_take && bit_cnt == 3'h7 && !cs_fall
    |=> rx_o.valid && bit_cnt == 3'h0 && tx_live)
    else $error("eighth rising edge did not close the byte");
  a_resp_first: assert property ($rose(so_oe_o) |-> $past(tx_live) && $past(sclk_fall))
    else $error("response drive started outside a falling edge after a byte");
  a_mode_latch: assert property (cs_fall |=> mode3_o == $past(pins.sclk))
    else $error("mode not taken from clock level at select");
  a_low_phase_out: assert property (tx_step |=> so_o == $past(tx_shift[7]) && so_oe_o)
    else $error("response bit not driven one cycle after falling edge");
  a_idle_quiet: assert property (deselect |=> !so_oe_o ##1 !so_oe_o [*2] or !deselect)
    else $error("serial output driven while deselected");
  a_new_command: assert property (cs_fall |=> bit_cnt == 3'h0 && !tx_live)
    else $error("chip select fall did not restart the command");

  c_mode0_select: cover property (cs_fall && !pins.sclk);
  c_mode3_select: cover property (cs_fall && pins.sclk);
  c_two_bytes: cover property (rx_o.valid ##[1:300] rx_o.valid);
  c_response_bit: cover property ($rose(so_oe_o));
endmodule
`default_nettype wire

// ===== dv/link_host.sv
/*
  Host model: makes the serial clock, selects and shifts bytes MSB first.
  Assumes a 100 MHz core clock; each clock phase lasts four core cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module link_host (
  input wire logic clk_i,
  input wire logic miso_i,
  output logic cs_b_o,
  output logic sclk_o,
  output logic si_o
);
  logic [7:0] rx [4];
  logic [7:0] rx_low [4];
  logic low_bit;
  // ==========================================================
  // Page rewrite bookkeeping for one sector; counts operations only
  localparam int SECTOR_PAGES = 8;
  localparam int REWRITE_SPAN = 50000;
  int op_count = 0;
  int page_ptr = 0;
  int last_sweep = 0;
  int done_at [SECTOR_PAGES];
  // Chip select idles high through device reset
  initial
  begin
    cs_b_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  // ==========================================================
  // Frames
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask
  task automatic stray(input int n);
    repeat (n)
    begin
      half();
      sclk_o = ~sclk_o;
    end
  endtask
  // One array operation: a direct program, or the program step after a buffer fill
  task automatic page_write(input int page);
    op_count++;
    done_at[page] = op_count;
  endtask
  // Sequential fill, then a hot page written again and again.
  // Normal host rewrites the pointed page after each write; a low-power
  // host waits and sweeps the whole sector just before the span runs out.
  task automatic page_pass(input logic low_power, input int writes);
    op_count = 0;
    page_ptr = 0;
    last_sweep = 0;
    for (int p = 0; p < SECTOR_PAGES; p++)
      page_write(p);
    for (int n = 0; n < writes; n++)
    begin
      page_write(0);
      if (!low_power)
      begin
        page_write(page_ptr);
        page_ptr = (page_ptr + 1) % SECTOR_PAGES;
      end
      else if (op_count - last_sweep >= REWRITE_SPAN - SECTOR_PAGES)
      begin
        for (int p = 0; p < SECTOR_PAGES; p++)
          page_write(p);
        last_sweep = op_count;
      end
    end
  endtask
  function automatic int oldest_age();
    int age;
    age = 0;
    for (int p = 0; p < SECTOR_PAGES; p++)
      if (op_count - done_at[p] > age)
        age = op_count - done_at[p];
    return age;
  endfunction
  // The reply to byte i is caught during byte i+1
  task automatic frame(input logic m3, input int nbits, input logic [31:0] tx);
    int j;
    rx = '{default: 8'h00};
    rx_low = '{default: 8'h00};
    sclk_o = m3;
    si_o = tx[31];
    half();
    cs_b_o = 1'b0;
    half();
    for (int k = 0; k < nbits; k++)
    begin
      if (sclk_o)
      begin
        half();
        sclk_o = 1'b0;
      end
      half();
      low_bit = miso_i;
      sclk_o = 1'b1;
      si_o = (k + 1 < nbits) ? tx[30 - k] : ~si_o;
      half();
      j = k - 8;
      if (j >= 0)
      begin
        rx[j / 8][7 - j % 8] = miso_i;
        rx_low[j / 8][7 - j % 8] = low_bit;
      end
      sclk_o = 1'b0;
    end
    half();
    sclk_o = m3;
    half();
    cs_b_o = 1'b1;
    si_o = ~si_o;
    half();
  endtask
endmodule
`default_nettype wire

// ===== dv/fast_serial_flash_link_bench.sv
/*
  Self-checking bench for the device end of the serial link.
  Assumes the host model in link_host drives all link pins.
*/
`timescale 1ns/1ns
`default_nettype none
module fast_serial_flash_link_bench;
  import serial_link_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] tx_data = 8'h3c;
  logic cs_b, sclk, si, so, so_oe, mode3, miso;
  rx_byte_t rx;
  int err_count = 0;
  int checked = 0;
  int ri = 0;
  logic [7:0] rxq [$];
  logic [7:0] resp [4] = '{8'h3c, 8'ha5, 8'h96, 8'h0f};
  always #5 core_clk = ~core_clk;
  // A released line shows the inverse of its last value
  assign miso = so_oe ? so : ~so;
  link_host host (.clk_i(core_clk), .miso_i(miso), .cs_b_o(cs_b), .sclk_o(sclk), .si_o(si));
  fast_serial_flash_link uut (.core_clk_i(core_clk), .rst_b_i(rst_b), .cs_b_i(cs_b),
    .sclk_i(sclk), .si_i(si), .so_o(so), .so_oe_o(so_oe), .tx_data_i(tx_data),
    .rx_o(rx), .mode3_o(mode3));
  always @(negedge core_clk)
    if (rx.valid === 1'b1)
    begin
      rxq.push_back(rx.data);
      ri = ri + 1;
      tx_data <= resp[ri % 4];
    end
  // ==========================================================
  // Helpers
  task automatic chk(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      err_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic run(input logic m3, input int nbits, input logic [31:0] tx);
    ri = 0;
    tx_data = resp[0];
    rxq.delete();
    host.frame(m3, nbits, tx);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_frame(input logic m3);
    logic [7:0] sent [3];
    sent = '{8'ha5, 8'h5a, 8'hc3};
    run(m3, 24, 32'ha55ac300);
    chk(rxq.size() == 3, "received byte count");
    for (int i = 0; i < 3; i++)
      chk(rxq[i] === sent[i], "received byte");
    for (int i = 0; i < 2; i++)
    begin
      chk(host.rx[i] === resp[i], "reply byte");
      chk(host.rx_low[i] === resp[i], "reply late in low phase");
    end
    chk(mode3 === m3, "clock mode");
    chk(so_oe === 1'b0, "output driven while deselected");
  endtask
  task automatic t_partial();
    run(1'b0, 5, 32'hf8000000);
    host.stray(16);
    chk(rxq.size() == 0 && so_oe === 1'b0, "activity while deselected");
    run(1'b0, 16, 32'h69e10000);
    chk(rxq.size() == 2 && rxq[0] === 8'h69 && rxq[1] === 8'he1, "restart");
    chk(host.rx[0] === resp[0], "reply after restart");
  endtask
  task automatic t_rewrite();
    host.page_pass(1'b0, 60000);
    chk(host.oldest_age() < 50000, "page missed its rewrite");
    host.page_pass(1'b1, 60000);
    chk(host.oldest_age() < 50000, "sector sweep too late");
  endtask
  initial
  begin
    #50000;
    err_count++;
    $display("wrong value at %0t: run hung", $time);
    end_sim();
  end
  initial
  begin
    repeat (4) @(negedge core_clk);
    rst_b = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(so_oe === 1'b0 && so === 1'b1 && mode3 === 1'b0, "reset state");
    t_frame(1'b0);
    t_frame(1'b1);
    t_partial();
    t_rewrite();
    end_sim();
  end
endmodule
`default_nettype wire
